// ===== core/msfr_pkg.sv
// Purpose: Shared constants and types for MACsec fault reporting.
// Assumes: AHB-Lite word registers, one clock hclk.
// Notes: Offsets are byte addresses within an 8-bit window.
package msfr_pkg;
   // Register byte offsets
   localparam logic [7:0] A_CTRL = 8'h00;
   localparam logic [7:0] A_PEND = 8'h04;
   localparam logic [7:0] A_ENA  = 8'h08;
   localparam logic [7:0] A_RXST = 8'h0c;
   localparam logic [7:0] A_TXST = 8'h10;
   localparam logic [7:0] A_WLO  = 8'h14;
   localparam logic [7:0] A_WHI  = 8'h18;
   localparam logic [7:0] A_TLO  = 8'h1c;
   localparam logic [7:0] A_THI  = 8'h20;
   localparam logic [7:0] A_SEL  = 8'h24;
   localparam logic [7:0] A_UPD  = 8'h28;
   localparam logic [7:0] A_AMSK = 8'h2c;
   localparam logic [7:0] A_GMSK = 8'h30;
   localparam logic [7:0] A_CLO  = 8'h34;
   localparam logic [7:0] A_CHI  = 8'h38;
   // Control bits
   localparam int C_RXDBG = 0;
   localparam int C_TXDBG = 1;
   localparam int C_XPN   = 2;
   // Pending and enable bit positions
   localparam int I_RCRY = 0;
   localparam int I_RCLS = 1;
   localparam int I_RCON = 2;
   localparam int I_RPST = 3;
   localparam int I_RMTU = 4;
   localparam int I_TCRY = 8;
   localparam int I_TCLS = 9;
   localparam int I_TPST = 10;
   localparam int I_TMTU = 11;
   localparam int PW     = 12;
   // Crypto status bits
   localparam int S_IN    = 0;
   localparam int S_OUT   = 1;
   localparam int S_PROC  = 2;
   localparam int S_CTX   = 3;
   localparam int S_THR   = 4;
   localparam int S_ROLL  = 5;
   localparam int S_FATAL = 14;
   localparam int ST_W    = 16;
   // Event vector widths
   localparam int GV_W  = 18;
   localparam int SV_W  = 13;
   localparam int RXG_W = 18;
   localparam int RXS_W = 13;
   localparam int TXG_W = 9;
   localparam int TXS_W = 6;
   // Reset values
   localparam logic [2:0]    R_CTRL = 3'h0;
   localparam logic [PW-1:0] R_ENA  = 12'h000;
   localparam logic [63:0]   R_WLVL = 64'hffff_ffff_ffff_ffff;
   localparam logic [GV_W-1:0] R_GMSK = 18'h00000;
   localparam logic [SV_W-1:0] R_AMSK = 13'h0000;

   typedef struct packed {
      logic        vld;
      logic        last;
      logic        fcs;
      logic [31:0] data;
   } msfr_word_t;

   typedef struct packed {
      logic            hit;
      logic [5:0]      ptr;
      logic            ctrl;
      logic [1:0]      tag;
      logic [GV_W-1:0] gvec;
      logic [SV_W-1:0] svec;
   } msfr_meta_t;

   typedef struct packed {
      logic short_pkt;
      logic out_err;
      logic flow_mis;
      logic ctx_err;
      logic fatal;
   } msfr_ce_t;

   typedef struct packed {
      logic classify;
      logic consist;
      logic postproc;
      logic mtu;
   } msfr_drop_t;
endpackage : msfr_pkg

// ===== core/msfr_fcs_stage.sv
// Purpose: One direction of the FCS fault-code replacement.
// Assumes: Meta is valid on the cycle the FCS word is presented.
// Notes: One register stage of latency on the frame words.
module msfr_fcs_stage
   import msfr_pkg::*;
#(
   parameter int GW = 18,
   parameter int SW = 13
) (
   input  wire logic            hclk,
   input  wire logic            hresetn,
   input  wire logic            dbg_en,
   input  wire logic [GV_W-1:0] gmask,
   input  wire logic [SV_W-1:0] smask,
   input  wire msfr_word_t      in_w,
   input  wire msfr_meta_t      meta,
   output msfr_word_t           out_r,
   output logic                 fail_r
);
   localparam logic [GV_W-1:0] GKEEP = GV_W'((64'h1 << GW) - 64'h1);
   localparam logic [SV_W-1:0] SKEEP = SV_W'((64'h1 << SW) - 64'h1);

   logic [GV_W-1:0] gv;
   logic [SV_W-1:0] sv;
   logic            fail;
   logic            hit_fcs;
   logic [31:0]     code;

   // Unused vector bits forced to zero
   assign gv = meta.gvec & GKEEP;
   assign sv = meta.svec & SKEEP;
   // Masked counter events count as security failure
   assign fail = |(gv & gmask) | |(sv & smask);
   assign hit_fcs = in_w.vld & in_w.fcs;
   // Fault code assembly
   assign code = {1'b1, meta.hit,
                  meta.hit ? meta.ptr
                           : {3'b000, meta.ctrl, meta.tag},
                  gv[13:0], sv[9:0]};

   // Frame word pass-through with FCS substitution
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         out_r  <= '0;
         fail_r <= 1'b0;
      end else begin
         out_r  <= in_w;
         fail_r <= hit_fcs & fail;
         if (hit_fcs && fail && dbg_en) begin
            out_r.data <= code;
         end
      end
   end

   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);

   chk_fcs_code: assert property (
      hit_fcs && fail && dbg_en |=> out_r.data == $past(code)
         && out_r.data[31])
      else $error("fault code not substituted");
   chk_fcs_keep: assert property (
      in_w.vld && !(hit_fcs && fail && dbg_en) |=> out_r.data ==
         $past(in_w.data))
      else $error("frame word altered without failure");
endmodule : msfr_fcs_stage

// ===== core/msfr_top.sv
// Purpose: Fault reporting, interrupts, SA number update, FCS codes.
// Assumes: Event inputs are one-cycle pulses on hclk.
// Notes: AHB-Lite slave with one wait state per transfer.
//
// The AHB-Lite slave port and the register offsets were chosen for this implementation.
module msfr_top
   import msfr_pkg::*;
#(
   parameter int NCTX = 64,
   parameter int CW   = 6
) (
   input  wire logic          hclk,
   input  wire logic          hresetn,
   input  wire logic          hsel,
   input  wire logic [31:0]   haddr,
   input  wire logic [1:0]    htrans,
   input  wire logic          hwrite,
   input  wire logic [2:0]    hsize,
   input  wire logic [31:0]   hwdata,
   input  wire logic          hready,
   output logic               hreadyout,
   output logic [31:0]        hrdata,
   output logic               hresp,
   input  wire msfr_ce_t      rx_ce,
   input  wire msfr_ce_t      tx_ce,
   input  wire msfr_drop_t    rx_drop,
   input  wire msfr_drop_t    tx_drop,
   input  wire logic          tx_pn_vld,
   input  wire logic [63:0]   tx_pn,
   input  wire logic          ctx_wr_vld,
   input  wire logic [CW-1:0] ctx_wr_idx,
   input  wire logic [63:0]   ctx_wr_pn,
   input  wire logic [CW-1:0] ctx_rd_idx,
   output logic [63:0]        ctx_rd_pn,
   input  wire msfr_word_t    rx_in,
   input  wire msfr_meta_t    rx_meta,
   output msfr_word_t         rx_out,
   output logic               rx_secfail,
   input  wire msfr_word_t    tx_in,
   input  wire msfr_meta_t    tx_meta,
   output msfr_word_t         tx_out,
   output logic               tx_secfail,
   output logic [4:0]         rx_irq,
   output logic [3:0]         tx_irq
);
   typedef enum logic {
      U_IDLE  = 1'b0,
      U_APPLY = 1'b1
   } msfr_upd_t;

   logic              ap_r;
   logic              wr_r;
   logic [7:0]        adr_r;
   logic              we;
   logic [2:0]        ctrl_r;
   logic [PW-1:0]     pend_r;
   logic [PW-1:0]     ena_r;
   logic [PW-1:0]     pset;
   logic [PW-1:0]     pend_now;
   logic [ST_W-1:0]   rx_st_r;
   logic [ST_W-1:0]   tx_st_r;
   logic [ST_W-1:0]   rx_set;
   logic [ST_W-1:0]   tx_set;
   logic [63:0]       wlvl_r;
   logic [63:0]       tgt_r;
   logic [CW-1:0]     sel_r;
   logic              upd_r;
   msfr_upd_t         ust_r;
   msfr_upd_t         ust_nxt;
   logic [GV_W-1:0]   gmask_r;
   logic [SV_W-1:0]   amask_r;
   logic [63:0]       ctx_pn [NCTX];
   logic [63:0]       tgt_eff;
   logic [63:0]       cur_pn;
   logic [63:0]       cur_eff;
   logic              xpn;
   logic              thr_hit;
   logic              roll_hit;
   logic [31:0]       rd_nxt;

   assign xpn = ctrl_r[C_XPN];
   assign we  = ap_r & wr_r;

   // Bus address phase capture and wait state
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ap_r      <= 1'b0;
         wr_r      <= 1'b0;
         adr_r     <= 8'h00;
         hreadyout <= 1'b1;
      end else if (hsel && htrans[1] && hready) begin
         ap_r      <= 1'b1;
         wr_r      <= hwrite;
         adr_r     <= {haddr[7:2], 2'b00};
         hreadyout <= 1'b0;
      end else if (ap_r) begin
         ap_r      <= 1'b0;
         hreadyout <= 1'b1;
      end
   end

   // Response is always OKAY
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hresp <= 1'b0;
      end else begin
         hresp <= 1'b0;
      end
   end

   // Read data mux, unmapped reads as zero
   always_comb begin
      rd_nxt = 32'h0000_0000;
      case (adr_r)
         A_CTRL: rd_nxt = {29'h0, ctrl_r};
         A_PEND: rd_nxt = {20'h0, pend_now};
         A_ENA:  rd_nxt = {20'h0, ena_r};
         A_RXST: rd_nxt = {16'h0, rx_st_r};
         A_TXST: rd_nxt = {16'h0, tx_st_r};
         A_WLO:  rd_nxt = wlvl_r[31:0];
         A_WHI:  rd_nxt = wlvl_r[63:32];
         A_TLO:  rd_nxt = tgt_r[31:0];
         A_THI:  rd_nxt = tgt_r[63:32];
         A_SEL:  rd_nxt = 32'(sel_r);
         A_UPD:  rd_nxt = {31'h0, upd_r};
         A_AMSK: rd_nxt = 32'(amask_r);
         A_GMSK: rd_nxt = 32'(gmask_r);
         A_CLO:  rd_nxt = ctx_pn[sel_r][31:0];
         A_CHI:  rd_nxt = ctx_pn[sel_r][63:32];
         default: rd_nxt = 32'h0000_0000;
      endcase
   end

   // Read data latched in the data phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0000_0000;
      end else if (ap_r && !wr_r) begin
         hrdata <= rd_nxt;
      end
   end

   // Control and mask registers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_r  <= R_CTRL;
         ena_r   <= R_ENA;
         gmask_r <= R_GMSK;
         amask_r <= R_AMSK;
      end else if (we) begin
         if (adr_r == A_CTRL) ctrl_r <= hwdata[2:0];
         if (adr_r == A_ENA) ena_r <= hwdata[PW-1:0];
         if (adr_r == A_GMSK) gmask_r <= hwdata[GV_W-1:0];
         if (adr_r == A_AMSK) amask_r <= hwdata[SV_W-1:0];
      end
   end

   // Sequence warning level
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wlvl_r <= R_WLVL;
      end else if (we) begin
         if (adr_r == A_WLO) wlvl_r[31:0] <= hwdata;
         if (adr_r == A_WHI) wlvl_r[63:32] <= hwdata;
      end
   end

   // Status set vectors from the crypto engines, plus threshold and rollover from the egress number watch on transmit
   always_comb begin
      rx_set = '0;
      rx_set[S_IN]    = rx_ce.short_pkt;
      rx_set[S_OUT]   = rx_ce.out_err;
      rx_set[S_FATAL] = rx_ce.fatal;
      rx_set[S_PROC]  = rx_ce.flow_mis;
      rx_set[S_CTX]   = rx_ce.ctx_err;
      tx_set = '0;
      tx_set[S_IN]    = tx_ce.short_pkt;
      tx_set[S_OUT]   = tx_ce.out_err;
      tx_set[S_FATAL] = tx_ce.fatal;
      tx_set[S_PROC]  = tx_ce.flow_mis;
      tx_set[S_CTX]   = tx_ce.ctx_err;
      tx_set[S_THR]   = thr_hit;
      tx_set[S_ROLL]  = roll_hit;
   end

   // Egress number watch, frames are never held
   assign thr_hit = tx_pn_vld & (xpn ? tx_pn > wlvl_r
                    : tx_pn[31:0] > wlvl_r[31:0]);
   assign roll_hit = tx_pn_vld & (xpn ? &tx_pn
                     : &tx_pn[31:0]);

   // Crypto status, write one clears, set wins
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rx_st_r <= '0;
         tx_st_r <= '0;
      end else begin
         if (we && adr_r == A_RXST) begin
            rx_st_r <= (rx_st_r & ~hwdata[ST_W-1:0]) | rx_set;
         end else begin
            rx_st_r <= rx_st_r | rx_set;
         end
         if (we && adr_r == A_TXST) begin
            tx_st_r <= (tx_st_r & ~hwdata[ST_W-1:0]) | tx_set;
         end else begin
            tx_st_r <= tx_st_r | tx_set;
         end
      end
   end

   // Drop sources per direction
   always_comb begin
      pset = '0;
      pset[I_RCLS] = rx_drop.classify;
      pset[I_RCON] = rx_drop.consist;
      pset[I_RPST] = rx_drop.postproc;
      pset[I_RMTU] = rx_drop.mtu;
      pset[I_TCLS] = tx_drop.classify;
      pset[I_TPST] = tx_drop.postproc;
      pset[I_TMTU] = tx_drop.mtu;
   end

   // Crypto pending follows its status register
   always_comb begin
      pend_now = pend_r;
      pend_now[I_RCRY] = |rx_st_r;
      pend_now[I_TCRY] = |tx_st_r;
   end

   // Sticky drop pending, write one clears, set wins
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pend_r <= '0;
      end else if (we && adr_r == A_PEND) begin
         pend_r <= (pend_r & ~hwdata[PW-1:0]) | pset;
      end else begin
         pend_r <= pend_r | pset;
      end
   end

   // Gated interrupt outputs
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rx_irq <= 5'h00;
         tx_irq <= 4'h0;
      end else begin
         rx_irq <= pend_now[4:0] & ena_r[4:0];
         tx_irq <= pend_now[11:8] & ena_r[11:8];
      end
   end

   // Update target and context selection
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tgt_r <= 64'h0;
         sel_r <= '0;
      end else if (we) begin
         if (adr_r == A_TLO) tgt_r[31:0] <= hwdata;
         if (adr_r == A_THI) tgt_r[63:32] <= hwdata;
         if (adr_r == A_SEL) sel_r <= hwdata[CW-1:0];
      end
   end

   // Update enable, set by software, cleared after apply
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         upd_r <= 1'b0;
      end else if (we && adr_r == A_UPD && hwdata[0]) begin
         upd_r <= 1'b1;
      end else if (ust_r == U_APPLY) begin
         upd_r <= 1'b0;
      end
   end

   // Update sequencer
   always_comb begin
      ust_nxt = ust_r;
      case (ust_r)
         U_IDLE:  if (upd_r) ust_nxt = U_APPLY;
         U_APPLY: ust_nxt = U_IDLE;
         default: ust_nxt = U_IDLE;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ust_r <= U_IDLE;
      end else begin
         ust_r <= ust_nxt;
      end
   end

   // Compare in the configured numbering width
   assign cur_pn  = (ctx_wr_vld && ctx_wr_idx == sel_r) ? ctx_wr_pn
                    : ctx_pn[sel_r];
   assign tgt_eff = xpn ? tgt_r : {32'h0, tgt_r[31:0]};
   assign cur_eff = xpn ? cur_pn : {32'h0, cur_pn[31:0]};

   // Context number storage, written with any value by the datapath, only raised by software
   always_ff @(posedge hclk) begin
      if (ctx_wr_vld) begin
         ctx_pn[ctx_wr_idx] <= ctx_wr_pn;
      end
      if (ust_r == U_APPLY && cur_eff < tgt_eff) begin
         ctx_pn[sel_r] <= tgt_eff;
      end
   end

   // Datapath read port of the context numbers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctx_rd_pn <= 64'h0;
      end else begin
         ctx_rd_pn <= ctx_pn[ctx_rd_idx];
      end
   end

   // Receive FCS fault-code stage
   msfr_fcs_stage #(
      .GW (RXG_W),
      .SW (RXS_W)
   ) u_rx_fcs (
      .hclk    (hclk),
      .hresetn (hresetn),
      .dbg_en  (ctrl_r[C_RXDBG]),
      .gmask   (gmask_r),
      .smask   (amask_r),
      .in_w    (rx_in),
      .meta    (rx_meta),
      .out_r   (rx_out),
      .fail_r  (rx_secfail)
   );

   // Transmit FCS fault-code stage
   msfr_fcs_stage #(
      .GW (TXG_W),
      .SW (TXS_W)
   ) u_tx_fcs (
      .hclk    (hclk),
      .hresetn (hresetn),
      .dbg_en  (ctrl_r[C_TXDBG]),
      .gmask   (gmask_r),
      .smask   (amask_r),
      .in_w    (tx_in),
      .meta    (tx_meta),
      .out_r   (tx_out),
      .fail_r  (tx_secfail)
   );

   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);

   chk_status_hold: assert property (
      rx_st_r[S_IN] && !(we && adr_r == A_RXST && hwdata[S_IN])
         |=> rx_st_r[S_IN])
      else $error("status bit lost without clear");
   chk_input_err: assert property (
      rx_ce.short_pkt |=> rx_st_r[S_IN] && pend_now[I_RCRY])
      else $error("input error not flagged");
   chk_flow_err: assert property (
      tx_ce.flow_mis |=> tx_st_r[S_PROC])
      else $error("flow mismatch not flagged");
   chk_thr_flag: assert property (
      tx_pn_vld && !xpn && tx_pn[31:0] > wlvl_r[31:0]
         |=> tx_st_r[S_THR])
      else $error("threshold not flagged");
   chk_roll_flag: assert property (
      tx_pn_vld && xpn && &tx_pn |=> tx_st_r[S_ROLL])
      else $error("rollover not flagged");
   chk_cls_irq: assert property (
      rx_drop.classify && ena_r[I_RCLS] ##1 ena_r[I_RCLS]
         |=> rx_irq[I_RCLS])
      else $error("classify drop irq missing");
   chk_con_pend: assert property (
      rx_drop.consist |=> pend_r[I_RCON])
      else $error("consistency drop not pending");
   chk_pst_pend: assert property (
      tx_drop.postproc |=> pend_r[I_TPST])
      else $error("post-processing drop not pending");
   chk_mtu_pend: assert property (
      rx_drop.mtu && !rx_drop.postproc && !(we && adr_r == A_PEND)
         |=> pend_r[I_RMTU] && pend_r[I_RPST] == $past(pend_r[I_RPST]))
      else $error("size drop not pending");
   chk_upd_clear: assert property (
      $rose(upd_r) |-> ##2 !upd_r)
      else $error("update enable not cleared");
   chk_upd_raise: assert property (
      ust_r == U_APPLY && !ctx_wr_vld |=> ctx_pn[$past(sel_r)] >=
         $past(cur_pn))
      else $error("context number lowered");
   chk_irq_mask: assert property (
      !ena_r[I_TMTU] |=> !tx_irq[3])
      else $error("masked source reached output");
endmodule : msfr_top

// ===== sim/msfr_top_test.sv
// Purpose: Self-checking bench for the fault reporting block.
// Assumes: AHB-Lite single word transfers, hready looped from hreadyout.
// Notes: Random meta and masks from a fixed seed, corner cases mixed in.
module msfr_top_test
   import msfr_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ps;

   logic              hclk, hresetn, hsel, hwrite, hresp, hreadyout;
   logic [31:0]       haddr, hwdata, hrdata, q, t, d, gm, sm, ex;
   logic [1:0]        htrans;
   wire logic         hready;
   msfr_ce_t          rx_ce, tx_ce;
   msfr_drop_t        rx_drop, tx_drop;
   logic              tx_pn_vld, ctx_wr_vld, rx_secfail, tx_secfail, fl;
   logic [63:0]       tx_pn, ctx_wr_pn, ctx_rd_pn;
   logic [5:0]        ctx_wr_idx, ctx_rd_idx;
   msfr_word_t        rx_in, tx_in, rx_out, tx_out;
   msfr_meta_t        rx_meta, tx_meta, m, me;
   logic [4:0]        rx_irq, rxe;
   logic [3:0]        tx_irq, txe;
   logic [63:0]       pnt [5];
   logic [31:0]       pne [5];
   int                error_cnt, tests_run;

   assign hready = hreadyout;

   // Clock at 20 MHz
   initial hclk = 1'b0;
   always #25 hclk = ~hclk;

   msfr_top #(.NCTX(64), .CW(6)) dut_u (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
      .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata),
      .hresp(hresp), .rx_ce(rx_ce), .tx_ce(tx_ce), .rx_drop(rx_drop),
      .tx_drop(tx_drop), .tx_pn_vld(tx_pn_vld), .tx_pn(tx_pn),
      .ctx_wr_vld(ctx_wr_vld), .ctx_wr_idx(ctx_wr_idx),
      .ctx_wr_pn(ctx_wr_pn), .ctx_rd_idx(ctx_rd_idx),
      .ctx_rd_pn(ctx_rd_pn), .rx_in(rx_in), .rx_meta(rx_meta),
      .rx_out(rx_out), .rx_secfail(rx_secfail), .tx_in(tx_in),
      .tx_meta(tx_meta), .tx_out(tx_out), .tx_secfail(tx_secfail),
      .rx_irq(rx_irq), .tx_irq(tx_irq)
   );

   // Value compare
   task chk(input logic [63:0] g, input logic [63:0] e);
      tests_run++;
      if (g !== e) begin
         error_cnt++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk

   // One AHB-Lite transfer, waits on hready in both phases
   task bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
      @(posedge hclk);
      hsel   <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr  <= {24'h0, a};
      do begin
         @(posedge hclk);
      end while (hready !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do begin
         @(posedge hclk);
      end while (hready !== 1'b1);
      q = hrdata;
      #1;
   endtask : bus

   task wr(input logic [7:0] a, input logic [31:0] wd);
      bus(1'b1, a, wd);
   endtask : wr

   task rdc(input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(q, e);
   endtask : rdc

   // Event pulse, then wait until the irq outputs settle
   task ev(input msfr_ce_t c, input msfr_drop_t r, input msfr_drop_t x);
      @(posedge hclk);
      rx_ce   <= c;
      tx_ce   <= c;
      rx_drop <= r;
      tx_drop <= x;
      @(posedge hclk);
      rx_ce   <= '0;
      tx_ce   <= '0;
      rx_drop <= '0;
      tx_drop <= '0;
      repeat (2) @(posedge hclk);
      #1;
   endtask : ev

   task pn_use(input logic [63:0] v);
      @(posedge hclk);
      tx_pn_vld <= 1'b1;
      tx_pn     <= v;
      @(posedge hclk);
      tx_pn_vld <= 1'b0;
   endtask : pn_use

   // Expected fault code for a failing frame
   function automatic logic [31:0] fcode(input msfr_meta_t mt);
      logic [5:0] p;
      p = mt.hit ? mt.ptr : {3'b000, mt.ctrl, mt.tag};
      return {1'b1, mt.hit, p, mt.gvec[13:0], mt.svec[9:0]};
   endfunction : fcode

   task complete_run;
      if (error_cnt == 0 && tests_run > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : complete_run

   // Watchdog against a hung bus or handshake
   initial begin
      #2ms;
      error_cnt++;
      complete_run();
   end

   // Main sequence
   initial begin
      {hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
      {rx_ce, tx_ce, rx_drop, tx_drop, tx_pn_vld, tx_pn} = '0;
      {ctx_wr_vld, ctx_wr_idx, ctx_wr_pn, ctx_rd_idx} = '0;
      {rx_in, tx_in, rx_meta, tx_meta} = '0;
      pnt = '{64'he000_0000, 64'hf000_0001, 64'hffff_ffff,
              64'hffff_ffff, '1};
      pne = '{32'h0, 32'h10, 32'h30, 32'h10, 32'h30};
      void'($urandom(32'hb090));
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      // Reset values and an unmapped place
      rdc(A_ENA, 32'h0);
      rdc(A_WLO, 32'hffff_ffff);
      rdc(A_GMSK, 32'h0);
      rdc(8'h3c, 32'h0);
      chk(hresp, 1'b0);
      // Crypto error status, write one to clear
      wr(A_ENA, 32'h0f1f);
      ev('1, '0, '0);
      chk(rx_irq, 5'h01);
      chk(tx_irq, 4'h1);
      rdc(A_RXST, 32'h400f);
      rdc(A_TXST, 32'h400f);
      wr(A_TXST, 32'h400f);
      rdc(A_TXST, 32'h0);
      wr(A_RXST, 32'h1);
      rdc(A_RXST, 32'h400e);
      wr(A_RXST, 32'h400e);
      rdc(A_RXST, 32'h0);
      chk({rx_irq, tx_irq}, 9'h000);
      // Each drop source, pending accumulates
      rxe = '0;
      txe = '0;
      for (int k = 0; k < 4; k++) begin
         ev('0, msfr_drop_t'(4'h8 >> k), msfr_drop_t'(4'h8 >> k));
         rxe = rxe | (5'h2 << k);
         txe = txe | ((k == 1) ? 4'h0 : (4'h2 << ((k == 0) ? 0 : k - 1)));
         chk({rx_irq,tx_irq}, {rxe,txe});
      end
      rdc(A_PEND, 32'h0e1e);
      wr(A_PEND, 32'h0e1e);
      rdc(A_PEND, 32'h0);
      chk({rx_irq, tx_irq}, 9'h0);
      // Masked source still pends
      wr(A_ENA, 32'h0);
      ev('0, msfr_drop_t'(4'h8), '0);
      chk(rx_irq, 5'h00);
      rdc(A_PEND, 32'h2);
      wr(A_PEND, 32'h2);
      // Warning level and rollover, 32 then 64 bit numbering
      wr(A_WLO, 32'hf000_0000);
      wr(A_WHI, 32'h0);
      wr(A_ENA, 32'h100);
      for (int i = 0; i < 5; i++) begin
         if (i == 3) wr(A_TXST, 32'h30);
         if (i == 3) wr(A_CTRL, 32'h4);
         pn_use(pnt[i]);
         rdc(A_TXST, pne[i]);
      end
      chk(tx_irq, 4'h1);
      wr(A_ENA, 32'h0);
      wr(A_TXST, 32'h30);
      rdc(A_TXST, 32'h0);
      wr(A_ENA, 32'h100);
      chk(tx_irq, 4'h0);
      // Ingress number update only raises
      @(posedge hclk);
      ctx_wr_vld <= 1'b1;
      ctx_wr_idx <= 6'h05;
      ctx_wr_pn  <= 64'd100;
      @(posedge hclk);
      ctx_wr_vld <= 1'b0;
      wr(A_CTRL, 32'h0);
      ex = 32'd100;
      for (int i = 0; i < 4; i++) begin
         t = (i == 0) ? 32'd50 : (i < 3) ? 32'd200
             : 32'd200 + $urandom_range(1000, 1);
         wr(A_TLO, t);
         wr(A_THI, 32'h0);
         wr(A_SEL, 32'h5);
         wr(A_UPD, 32'h1);
         rdc(A_UPD, 32'h0);
         ex = (t > ex) ? t : ex;
         rdc(A_CLO, ex);
      end
      ctx_rd_idx <= 6'h05;
      repeat (2) @(posedge hclk);
      #1;
      chk(ctx_rd_pn, {32'h0, ex});
      // Fault code replacement, debug on then off
      wr(A_CTRL, 32'h3);
      gm = $urandom;
      sm = $urandom;
      wr(A_GMSK, gm);
      wr(A_AMSK, sm);
      for (int i = 0; i < 12; i++) begin
         if (i == 8) wr(A_CTRL, 32'h0);
         m = msfr_meta_t'(41'({$urandom, $urandom}));
         m.hit = i[1];
         if (i < 2) m.gvec = '0;
         if (i < 2) m.svec = '0;
         if (i[0] && i < 4) m.gvec[17:9] = '0;
         if (i[0] && i < 4) m.svec[12:6] = '0;
         // Transmit vectors carry nothing above their used bits
         me = m;
         if (i[0]) me.gvec[17:9] = '0;
         if (i[0]) me.svec[12:6] = '0;
         d = $urandom;
         fl = |(me.gvec & gm[17:0]) | |(me.svec & sm[12:0]);
         @(posedge hclk);
         if (i[0]) tx_in <= msfr_word_t'({3'b111, d});
         else rx_in <= msfr_word_t'({3'b111, d});
         if (i[0]) tx_meta <= m;
         else rx_meta <= m;
         @(posedge hclk);
         rx_in <= '0;
         tx_in <= '0;
         #1;
         ex = (fl && i < 8) ? fcode(me) : d;
         chk(i[0] ? tx_out : rx_out, {3'b111, ex});
         chk(i[0]?tx_secfail:rx_secfail, fl);
      end
      complete_run();
   end
endmodule : msfr_top_test
